/* File: rdm_cmd_if.sv */
// Command, address and data strobe logic of a registered memory module.
// Assumes the controller's pins are asynchronous to clk_sys and slow against it.
//
// Overview of operation
// - Commands are taken only while device_select_n is low; burst data are taken regardless of it.
// - Command inputs are registered only at master_tick rising edges.
// - Bank activate latches the 14-bit row address from address lines.
// - Read or write takes column from lines 0 to 9 and 11 as burst start.
// - Precharge with auto_close_flag high closes every bank.
// - Precharge with auto_close_flag low closes only the selected bank.
// - Read or write with auto_close_flag high closes its bank after the burst.
// - Eight banks, chosen by three bank select lines, first line least significant.
// - clock_gate_en low enters power-down or self-refresh; high exits it.
// - Module drives data_strobe for reads, controller drives it for writes.
// - Write data are captured on the controller's data_strobe edges.
// - Reset low clears all command and address registers.
// - Parity mismatch on address and control asserts parity_fault_n.
// - Read latency is the component latency plus one master_tick.
// - No byte masking; every byte of a write burst is written.
// - Command is decoded from the three strobes with device_select_n.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module rdm_cmd_if #(
  parameter int COMP_LAT = rdm_pkg::COMP_LAT_DEF
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Controller command side.
  input wire logic master_tick,
  input wire rdm_pkg::rdm_cmd_pins_t cmd_pins,
  output logic parity_fault_n,
  // Data pins, split into input, output and enable.
  input wire logic [rdm_pkg::DQ_W-1:0] dq_in,
  output logic [rdm_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic data_strobe_in,
  output logic data_strobe_out,
  output logic data_strobe_oe,
  // Register port.
  input wire logic [rdm_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt.
  output logic irq
);

  localparam logic [rdm_pkg::LAT_W-1:0] MOD_LAT =
    rdm_pkg::LAT_W'(COMP_LAT + rdm_pkg::MOD_LAT_ADD);
  localparam logic [rdm_pkg::BEAT_W-1:0] LAST_BEAT = rdm_pkg::BEAT_W'(rdm_pkg::BURST_LEN);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  rdm_pkg::rdm_cmd_pins_t pin_s1_q;
  rdm_pkg::rdm_cmd_pins_t pin_s2_q;
  logic [2:0] tick_q;
  logic [rdm_pkg::DQ_W-1:0] dq_s1_q;
  logic [rdm_pkg::DQ_W-1:0] dq_s2_q;
  logic [2:0] dqs_q;
  logic tick_rise;
  logic tick_edge;
  logic dqs_edge;

  // Every pin passes two flops; the third tap only serves edge detection.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      tick_q <= 3'h0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dqs_q <= 3'h0;
    end else begin
      pin_s1_q <= cmd_pins;
      pin_s2_q <= pin_s1_q;
      tick_q <= {tick_q[1:0], master_tick};
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      dqs_q <= {dqs_q[1:0], data_strobe_in};
    end
  end

  // Edges of the master tick and of the write strobe.
  assign tick_rise = tick_q[1] & ~tick_q[2];
  assign tick_edge = tick_q[1] ^ tick_q[2];
  assign dqs_edge = dqs_q[1] ^ dqs_q[2];

  // ----------------------------------------------------------------
  // Command decode and parity
  // ----------------------------------------------------------------
  rdm_pkg::rdm_cmd_t cmd;
  rdm_pkg::rdm_pwr_t pwr_q;
  rdm_pkg::rdm_bst_t bst_q;
  logic selected;
  logic cmd_go;
  logic par_bad;
  logic ap;
  logic [rdm_pkg::BANK_W-1:0] bank;
  logic [rdm_pkg::COL_W-1:0] col;
  logic [rdm_pkg::NUM_BANKS-1:0] open_q;
  logic bank_is_open;
  logic rw_go;
  logic closed_err;
  logic fault_q;

  // Commands count only on a tick rise with the module selected and awake.
  assign cmd = rdm_pkg::rdm_cmd_t'({pin_s2_q.row_strobe_n, pin_s2_q.column_strobe_n,
                                    pin_s2_q.write_strobe_n});
  assign selected = tick_rise & ~pin_s2_q.device_select_n;
  assign cmd_go = selected & (pwr_q == rdm_pkg::PWR_ACTIVE);
  assign ap = pin_s2_q.addr_line[rdm_pkg::AP_BIT];
  assign bank = pin_s2_q.bank_sel;
  assign col = {pin_s2_q.addr_line[11], pin_s2_q.addr_line[9:0]};
  assign bank_is_open = open_q[bank];
  assign rw_go = cmd_go & (cmd == rdm_pkg::CMD_READ || cmd == rdm_pkg::CMD_WRITE) &
                 (bst_q == rdm_pkg::BST_IDLE) & bank_is_open;
  assign closed_err = cmd_go & (cmd == rdm_pkg::CMD_READ || cmd == rdm_pkg::CMD_WRITE) &
                      ~bank_is_open;

  // Even parity over address, bank, strobes and the check bit.
  assign par_bad = selected & (^{pin_s2_q.addr_line, pin_s2_q.bank_sel,
                                 pin_s2_q.row_strobe_n, pin_s2_q.column_strobe_n,
                                 pin_s2_q.write_strobe_n, pin_s2_q.cmd_check_bit});

  // Fault holds from the cycle after the bad command to the next tick rise.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (tick_rise) begin
      fault_q <= par_bad;
    end
  end
  assign parity_fault_n = ~fault_q;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  logic lowpwr_ev;

  // Gate low enters a low power state; gate high leaves it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= rdm_pkg::PWR_ACTIVE;
    end else if (tick_rise) begin
      case (pwr_q)
        rdm_pkg::PWR_ACTIVE: begin
          if (!pin_s2_q.clock_gate_en) begin
            if (selected && cmd == rdm_pkg::CMD_REFRESH) begin
              pwr_q <= rdm_pkg::PWR_SELF;
            end else begin
              pwr_q <= rdm_pkg::PWR_DOWN;
            end
          end
        end
        rdm_pkg::PWR_DOWN, rdm_pkg::PWR_SELF: begin
          if (pin_s2_q.clock_gate_en) begin
            pwr_q <= rdm_pkg::PWR_ACTIVE;
          end
        end
        default: pwr_q <= rdm_pkg::PWR_ACTIVE;
      endcase
    end
  end
  assign lowpwr_ev = tick_rise & (pwr_q == rdm_pkg::PWR_ACTIVE) & ~pin_s2_q.clock_gate_en;

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  logic [rdm_pkg::LAT_W-1:0] lat_q;
  logic [rdm_pkg::BEAT_W-1:0] beat_q;
  logic [rdm_pkg::BANK_W-1:0] bst_bank_q;
  logic [rdm_pkg::COL_W-1:0] bst_col_q;
  logic bst_ap_q;
  logic rd_end;
  logic wr_end;
  logic burst_close;

  assign rd_end = (bst_q == rdm_pkg::BST_RD_DATA) & tick_edge & (beat_q == LAST_BEAT);
  assign wr_end = (bst_q == rdm_pkg::BST_WR_DATA) & dqs_edge & (beat_q == LAST_BEAT - 3'h1);
  assign burst_close = (rd_end | wr_end) & bst_ap_q;

  // Sequences one read or write burst at a time.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bst_q <= rdm_pkg::BST_IDLE;
      lat_q <= '0;
      beat_q <= '0;
      bst_bank_q <= '0;
      bst_col_q <= '0;
      bst_ap_q <= 1'b0;
    end else begin
      case (bst_q)
        rdm_pkg::BST_IDLE: begin
          if (rw_go) begin
            bst_bank_q <= bank;
            bst_col_q <= col;
            bst_ap_q <= ap;
            beat_q <= '0;
            lat_q <= MOD_LAT;
            bst_q <= (cmd == rdm_pkg::CMD_READ) ? rdm_pkg::BST_RD_WAIT : rdm_pkg::BST_WR_DATA;
          end
        end
        rdm_pkg::BST_RD_WAIT: begin
          if (tick_rise) begin
            lat_q <= lat_q - 4'h1;
            if (lat_q == 4'h1) begin
              bst_q <= rdm_pkg::BST_RD_DATA;
              beat_q <= 3'h1;
            end
          end
        end
        rdm_pkg::BST_RD_DATA: begin
          if (rd_end) begin
            bst_q <= rdm_pkg::BST_IDLE;
          end else if (tick_edge) begin
            beat_q <= beat_q + 3'h1;
          end
        end
        rdm_pkg::BST_WR_DATA: begin
          if (wr_end) begin
            bst_q <= rdm_pkg::BST_IDLE;
          end else if (dqs_edge) begin
            beat_q <= beat_q + 3'h1;
          end
        end
        default: bst_q <= rdm_pkg::BST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data storage and data pins
  // ----------------------------------------------------------------
  logic [rdm_pkg::DQ_W-1:0] mem [0:(1 << rdm_pkg::MEM_AW)-1];
  logic [rdm_pkg::COL_LSB_W-1:0] rd_beat;

  // Word address inside the burst wraps within the column group.
  function automatic logic [rdm_pkg::MEM_AW-1:0] mem_idx(
    input logic [rdm_pkg::BANK_W-1:0] b,
    input logic [rdm_pkg::COL_W-1:0] c,
    input logic [rdm_pkg::COL_LSB_W-1:0] n
  );
    mem_idx = {b, rdm_pkg::COL_LSB_W'(c[rdm_pkg::COL_LSB_W-1:0] + n)};
  endfunction : mem_idx

  // Whole words are written; there is no byte mask.
  always_ff @(posedge clk_sys) begin
    if (bst_q == rdm_pkg::BST_WR_DATA && dqs_edge) begin
      mem[mem_idx(bst_bank_q, bst_col_q, beat_q[rdm_pkg::COL_LSB_W-1:0])] <= dq_s2_q;
    end
  end

  assign rd_beat = (bst_q == rdm_pkg::BST_RD_WAIT) ? 3'h0 : beat_q[rdm_pkg::COL_LSB_W-1:0];

  // Read beats launch on both tick edges, strobe edge aligned with data.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      data_strobe_out <= 1'b0;
      data_strobe_oe <= 1'b0;
    end else if ((bst_q == rdm_pkg::BST_RD_WAIT && tick_rise && lat_q == 4'h1) ||
                 (bst_q == rdm_pkg::BST_RD_DATA && tick_edge && !rd_end)) begin
      dq_out <= mem[mem_idx(bst_bank_q, bst_col_q, rd_beat)];
      dq_oe <= 1'b1;
      data_strobe_out <= ~rd_beat[0];
      data_strobe_oe <= 1'b1;
    end else if (rd_end) begin
      dq_oe <= 1'b0;
      data_strobe_out <= 1'b0;
      data_strobe_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bank table
  // ----------------------------------------------------------------
  logic [rdm_pkg::ROW_W-1:0] row_q [0:rdm_pkg::NUM_BANKS-1];
  logic [rdm_pkg::NUM_BANKS-1:0] pre_onehot;

  assign pre_onehot = rdm_pkg::NUM_BANKS'(1) << bank;

  // One open flag and row per bank.
  for (genvar g = 0; g < rdm_pkg::NUM_BANKS; g++) begin : g_bank
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        open_q[g] <= 1'b0;
        row_q[g] <= '0;
      end else if (cmd_go && cmd == rdm_pkg::CMD_ACTIVATE && bank == g) begin
        open_q[g] <= 1'b1;
        row_q[g] <= pin_s2_q.addr_line;
      end else if (cmd_go && cmd == rdm_pkg::CMD_PRECHARGE && (ap || bank == g)) begin
        open_q[g] <= 1'b0;
      end else if (burst_close && bst_bank_q == g) begin
        open_q[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and register port
  // ----------------------------------------------------------------
  logic [rdm_pkg::ST_W-1:0] st_q;
  logic [rdm_pkg::ST_W-1:0] mask_q;
  logic [rdm_pkg::ST_W-1:0] ev;

  assign ev[rdm_pkg::ST_PARITY] = par_bad;
  assign ev[rdm_pkg::ST_LOWPWR] = lowpwr_ev;
  assign ev[rdm_pkg::ST_CLOSED] = closed_err;

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= rdm_pkg::STATUS_RST;
    end else if (reg_wr && reg_addr == rdm_pkg::OFS_STATUS) begin
      st_q <= (st_q & ~reg_wdata[rdm_pkg::ST_W-1:0]) | ev;
    end else begin
      st_q <= st_q | ev;
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_q <= rdm_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == rdm_pkg::OFS_MASK) begin
      mask_q <= reg_wdata[rdm_pkg::ST_W-1:0];
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        rdm_pkg::OFS_STATUS: reg_rdata <= 32'(st_q);
        rdm_pkg::OFS_MASK: reg_rdata <= 32'(mask_q);
        rdm_pkg::OFS_BANKS: reg_rdata <= 32'(open_q);
        rdm_pkg::OFS_POWER: reg_rdata <= 32'({bst_q, pwr_q});
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  assign irq = |(st_q & mask_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [rdm_pkg::LAT_W-1:0] rd_ticks_q;

  // Counts tick rises from read acceptance to the first launched beat.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_ticks_q <= '0;
    end else if (rw_go && cmd == rdm_pkg::CMD_READ) begin
      rd_ticks_q <= '0;
    end else if (tick_rise && bst_q == rdm_pkg::BST_RD_WAIT) begin
      rd_ticks_q <= rd_ticks_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  parity_fault_a: assert property (par_bad |=> !parity_fault_n [*3])
    else $error("parity fault not raised");
  parity_clear_a: assert property (tick_rise && !par_bad |=> parity_fault_n)
    else $error("parity fault not cleared");
  deselect_hold_a: assert property (tick_rise && pin_s2_q.device_select_n &&
                                    bst_q == rdm_pkg::BST_IDLE |=> $stable(open_q))
    else $error("deselected command changed banks");
  activate_row_a: assert property (cmd_go && cmd == rdm_pkg::CMD_ACTIVATE |=>
    open_q[$past(bank)] && row_q[$past(bank)] == $past(pin_s2_q.addr_line))
    else $error("activate did not latch row");
  precharge_all_a: assert property (cmd_go && cmd == rdm_pkg::CMD_PRECHARGE && ap |=>
                                    open_q == '0)
    else $error("precharge all left a bank open");
  precharge_one_a: assert property (cmd_go && cmd == rdm_pkg::CMD_PRECHARGE && !ap &&
    bst_q == rdm_pkg::BST_IDLE |=> open_q == ($past(open_q) & ~$past(pre_onehot)))
    else $error("single precharge wrong banks");
  read_latency_a: assert property ($rose(dq_oe) |-> rd_ticks_q == MOD_LAT)
    else $error("read latency wrong");
  auto_close_a: assert property (burst_close |=> !open_q[$past(bst_bank_q)])
    else $error("auto close did not close bank");
  power_enter_a: assert property (lowpwr_ev |=> pwr_q != rdm_pkg::PWR_ACTIVE ##1
                                  pwr_q != rdm_pkg::PWR_ACTIVE)
    else $error("low power not entered");
  strobe_own_a: assert property (data_strobe_oe |-> dq_oe &&
                                 bst_q == rdm_pkg::BST_RD_DATA)
    else $error("strobe driven outside read");

  activate_c: cover property (cmd_go && cmd == rdm_pkg::CMD_ACTIVATE);
  read_burst_c: cover property (rd_end);
  write_burst_c: cover property (wr_end);
  parity_c: cover property (par_bad);

endmodule : rdm_cmd_if

/* File: rdm_cmd_if_test.sv */
// Testbench of the registered memory module command interface.
// Assumes the host model file is compiled first; registers are reached over the plain port.
`timescale 1ns/1ps
module rdm_cmd_if_test;
  localparam int LAT = rdm_pkg::COMP_LAT_DEF + rdm_pkg::MOD_LAT_ADD;
  localparam rdm_pkg::rdm_cmd_t ACT = rdm_pkg::CMD_ACTIVATE;
  localparam rdm_pkg::rdm_cmd_t PRE = rdm_pkg::CMD_PRECHARGE;
  localparam rdm_pkg::rdm_cmd_t NOP = rdm_pkg::CMD_NOP;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [rdm_pkg::REG_AW-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic master_tick, parity_fault_n, dq_oe, ds_out, ds_oe, ds_drv, irq;
  rdm_pkg::rdm_cmd_pins_t cmd_pins;
  logic [71:0] dq_out, dq_drv;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  // System clock of 10 ns.
  always #5 clk_sys = ~clk_sys;

  rdm_host_model host (.master_tick(master_tick), .cmd_pins(cmd_pins), .dq_drv(dq_drv),
    .ds_drv(ds_drv));

  // Shared pins resolve to whichever side has its enable up.
  rdm_cmd_if #(.COMP_LAT(rdm_pkg::COMP_LAT_DEF)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .master_tick(master_tick), .cmd_pins(cmd_pins), .parity_fault_n(parity_fault_n),
    .dq_in(dq_oe ? dq_out : dq_drv), .dq_out(dq_out), .dq_oe(dq_oe),
    .data_strobe_in(ds_oe ? ds_out : ds_drv), .data_strobe_out(ds_out),
    .data_strobe_oe(ds_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Let the write land before a caller looks at what it drives.
    #1;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic reg_check(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(what, 72'(reg_rdata), 72'(exp));
  endtask : reg_check

  task automatic c(input rdm_pkg::rdm_cmd_t op, input logic [2:0] bank,
                   input logic [13:0] addr, input logic cke = 1'b1, input logic bad = 1'b0);
    host.cmd(op, bank, addr, 1'b0, cke, bad);
  endtask : c

  // Counts ticks from the read command to the first driven beat, then checks four beats.
  task automatic read_burst(input logic [7:0] s);
    int n;
    int t0;
    logic prev;
    t0 = host.tick_count;
    fork
      host.idle(LAT + 3);
      begin
        n = 0;
        while (dq_oe !== 1'b1 && n < 200) begin
          @(posedge clk_sys);
          #1;
          n++;
        end
        check("read latency", 72'(host.tick_count - t0), 72'(LAT));
        for (int b = 0; b < 4; b++) begin
          check("read beat", dq_out, {9{s + 8'(b)}});
          check("read strobe", 72'(ds_out), 72'(b % 2 == 0));
          check("strobe enable", 72'(ds_oe), 72'(1));
          prev = ds_out;
          n = 0;
          while (ds_out === prev && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
          end
        end
      end
    join
    check("read release", 72'({dq_oe, ds_oe}), 72'(0));
  endtask : read_burst

  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("fault reset", 72'(parity_fault_n), 72'(1));
    reg_check("status reset", rdm_pkg::OFS_STATUS, 32'h0);
    reg_check("mask reset", rdm_pkg::OFS_MASK, 32'h0);
    reg_check("banks reset", rdm_pkg::OFS_BANKS, 32'h0);
    reg_check("power reset", rdm_pkg::OFS_POWER, 32'h0);
    reg_check("unmapped", 4'h2, 32'h0);
    c(ACT, 3'h5, 14'h3fff);
    c(ACT, 3'h1, 14'h0001);
    c(ACT, 3'h2, 14'h2000);
    host.cmd(ACT, 3'h0, 14'h0, 1'b1, 1'b1, 1'b0);
    host.set_pins(ACT, 3'h7, 14'h0, 1'b0, 1'b1, 1'b0);
    #200;
    c(NOP, 3'h0, 14'h0);
    reg_check("open banks", rdm_pkg::OFS_BANKS, 32'h26);
    c(PRE, 3'h2, 14'h0);
    reg_check("one closed", rdm_pkg::OFS_BANKS, 32'h22);
    c(rdm_pkg::CMD_WRITE, 3'h5, 14'h0c06);
    host.write_burst(8'h40);
    reg_check("auto closed", rdm_pkg::OFS_BANKS, 32'h02);
    c(ACT, 3'h5, 14'h0);
    c(rdm_pkg::CMD_READ, 3'h5, 14'h0806);
    read_burst(8'h40);
    reg_check("stays open", rdm_pkg::OFS_BANKS, 32'h22);
    c(PRE, 3'h1, 14'h0400);
    reg_check("all closed", rdm_pkg::OFS_BANKS, 32'h0);
    c(rdm_pkg::CMD_READ, 3'h3, 14'h0);
    reg_check("closed access", rdm_pkg::OFS_STATUS, 32'h4);
    check("irq masked", 72'(irq), 72'(0));
    reg_write(rdm_pkg::OFS_MASK, 32'h7);
    check("irq raised", 72'(irq), 72'(1));
    reg_write(rdm_pkg::OFS_STATUS, 32'h4);
    check("irq cleared", 72'(irq), 72'(0));
    c(NOP, 3'h6, 14'h1234, 1'b1, 1'b1);
    check("fault low", 72'(parity_fault_n), 72'(0));
    reg_check("parity status", rdm_pkg::OFS_STATUS, 32'h1);
    check("irq parity", 72'(irq), 72'(1));
    c(NOP, 3'h6, 14'h1234);
    check("fault high", 72'(parity_fault_n), 72'(1));
    reg_write(rdm_pkg::OFS_STATUS, 32'h1);
    c(NOP, 3'h0, 14'h0, 1'b0);
    reg_check("power down", rdm_pkg::OFS_POWER, 32'h1);
    c(ACT, 3'h4, 14'h0, 1'b0);
    c(NOP, 3'h0, 14'h0);
    reg_check("power up", rdm_pkg::OFS_POWER, 32'h0);
    reg_check("ignored asleep", rdm_pkg::OFS_BANKS, 32'h0);
    c(rdm_pkg::CMD_REFRESH, 3'h0, 14'h0, 1'b0);
    reg_check("self refresh", rdm_pkg::OFS_POWER, 32'h2);
    c(NOP, 3'h0, 14'h0);
    reg_check("awake", rdm_pkg::OFS_POWER, 32'h0);
    reg_check("low power flag", rdm_pkg::OFS_STATUS, 32'h2);
    print_verdict();
  end
endmodule : rdm_cmd_if_test

/* File: rdm_host_model.sv */
// Partner model: the memory controller that drives command pins, write strobe and write data.
// Assumes the module samples these pins with its own faster clock; tick stands still between frames.
`timescale 1ns/1ps
module rdm_host_model (
  // Controller clock and command pins.
  output logic master_tick,
  output rdm_pkg::rdm_cmd_pins_t cmd_pins,
  // Write data and write strobe as driven by the controller.
  output logic [rdm_pkg::DQ_W-1:0] dq_drv,
  output logic ds_drv
);
  int tick_count = 0;

  // Pins start deselected, tick and strobe standing low.
  initial begin
    master_tick = 1'b0;
    ds_drv = 1'b0;
    dq_drv = 72'h0;
    set_pins(rdm_pkg::CMD_NOP, 3'h0, 14'h0, 1'b1, 1'b1, 1'b0);
  end

  // Presents one command; the check bit keeps the ones count even unless bad is set.
  task automatic set_pins(input rdm_pkg::rdm_cmd_t op, input logic [2:0] bank,
                          input logic [13:0] addr, input logic sel, input logic cke,
                          input logic bad);
    cmd_pins.device_select_n = sel;
    {cmd_pins.row_strobe_n, cmd_pins.column_strobe_n, cmd_pins.write_strobe_n} = op;
    cmd_pins.clock_gate_en = cke;
    cmd_pins.bank_sel = bank;
    cmd_pins.addr_line = addr;
    cmd_pins.cmd_check_bit = ^{addr, bank, op} ^ bad;
  endtask : set_pins

  // One tick period; pins changed a half period before the rise stay put past it.
  task automatic tick();
    #40;
    master_tick = 1'b1;
    tick_count++;
    #40;
    master_tick = 1'b0;
  endtask : tick

  // Issues one command in its own tick and then lets the tick stand still.
  task automatic cmd(input rdm_pkg::rdm_cmd_t op, input logic [2:0] bank,
                     input logic [13:0] addr, input logic sel, input logic cke,
                     input logic bad);
    set_pins(op, bank, addr, sel, cke, bad);
    tick();
    #40;
  endtask : cmd

  // Runs idle ticks with a valid selected no-operation.
  task automatic idle(input int n);
    set_pins(rdm_pkg::CMD_NOP, 3'h0, 14'h0, 1'b0, 1'b1, 1'b0);
    repeat (n) tick();
  endtask : idle

  // Four write beats, strobe edges placed on tick edges, data centred on them.
  task automatic write_burst(input logic [7:0] s);
    set_pins(rdm_pkg::CMD_NOP, 3'h0, 14'h0, 1'b0, 1'b1, 1'b0);
    for (int b = 0; b < 4; b++) begin
      dq_drv = {9{s + 8'(b)}};
      #20;
      ds_drv = ~ds_drv;
      master_tick = ds_drv;
      if (ds_drv) tick_count++;
      #20;
    end
    dq_drv = ~dq_drv;
  endtask : write_burst
endmodule : rdm_host_model

/* File: rdm_pkg.sv */
// Shared constants and types of the registered memory module command interface.
// Assumes a single system clock domain; pins reach it through synchronisers.
package rdm_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int ROW_W = 14;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int COL_W = 11;
  localparam int AP_BIT = 10;
  localparam int DQ_W = 72;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 3;
  localparam int COL_LSB_W = 3;
  localparam int MEM_AW = BANK_W + COL_LSB_W;
  localparam int LAT_W = 4;
  localparam int COMP_LAT_DEF = 5;
  localparam int MOD_LAT_ADD = 1;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'h0;
  localparam logic [REG_AW-1:0] OFS_MASK = 4'h4;
  localparam logic [REG_AW-1:0] OFS_BANKS = 4'h8;
  localparam logic [REG_AW-1:0] OFS_POWER = 4'hc;
  localparam int ST_W = 3;
  localparam int ST_PARITY = 0;
  localparam int ST_LOWPWR = 1;
  localparam int ST_CLOSED = 2;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // Command encoding on row, column and write strobes.
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_RSVD = 3'b110,
    CMD_NOP = 3'b111
  } rdm_cmd_t;

  // Power state of the module.
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF = 2'b10
  } rdm_pwr_t;

  // Data burst engine state.
  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_RD_WAIT = 2'b01,
    BST_RD_DATA = 2'b10,
    BST_WR_DATA = 2'b11
  } rdm_bst_t;

  // Command and address pins sampled together.
  typedef struct packed {
    logic device_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic clock_gate_en;
    logic [BANK_W-1:0] bank_sel;
    logic [ROW_W-1:0] addr_line;
    logic cmd_check_bit;
  } rdm_cmd_pins_t;

endpackage : rdm_pkg
